// ### src/dps_spi_port.v
`timescale 1ns/1ps
`include "dps_map.vh"
module dps_spi_port #(
	parameter NV_WRITE_CYCLES = `DPS_NV_WRITE_MS * `DPS_CORE_CLK_KHZ
) (
	input  wire       core_clk,         // 25 MHz core clock
	input  wire       reset,            // async, active high
	input  wire       sck,              // serial clock pin
	input  wire       cs_n,             // chip select pin, low active
	input  wire       sdi,              // serial data in pin
	output reg        sdo_out,          // serial data out level
	output reg        sdo_oe,           // serial data out enable
	output reg  [7:0] wiper0_code,      // wiper code register 0
	output reg  [7:0] wiper1_code,      // wiper code register 1
	output reg        dcp_enable,       // low forces shutdown
	output reg        active_mode,      // high when not in standby
	output reg        nv_write_pending  // stored write running
);
	localparam [1:0] EX_IDLE  = 2'h0;
	localparam [1:0] EX_DRAIN = 2'h1;
	localparam [1:0] EX_FLUSH = 2'h2;
	localparam [7:0] ACR_RST  = `DPS_ACR_RESET;

	// input synchronisers
	reg [1:0] sck_sync_reg;
	reg [1:0] cs_sync_reg;
	reg [1:0] sdi_sync_reg;
	reg       sck_prev_reg;
	reg       cs_prev_reg;

	// serial engine
	reg       armed_reg;
	reg [2:0] bit_cnt_reg;
	reg       inst_done_reg;
	reg [7:0] rx_reg;
	reg [7:0] inst_reg;
	reg [7:0] tx_reg;
	reg       tx_bit_reg;

	// executor
	reg [1:0] ex_state_reg;
	reg [4:0] ex_addr_reg;
	reg       ex_nv_reg;
	reg       nv_start_reg;

	// register storage
	reg [7:0] acr_reg;
	reg [7:0] ivr0_reg;
	reg [7:0] ivr1_reg;
	reg [7:0] gp_mem [0:15];

	wire       sck_s     = sck_sync_reg[1];
	wire       cs_s      = cs_sync_reg[1];
	wire       sdi_s     = sdi_sync_reg[1];
	wire       sck_rise  = sck_s & ~sck_prev_reg;
	wire       sck_fall  = ~sck_s & sck_prev_reg;
	wire       cs_fall   = ~cs_s & cs_prev_reg;
	wire       cs_rise   = cs_s & ~cs_prev_reg;
	wire       selected  = armed_reg & ~cs_s;
	wire       nv_busy;
	wire [7:0] rx_next   = {rx_reg[6:0], sdi_s};
	wire       byte_done = selected & sck_rise &
	                       (bit_cnt_reg == `DPS_BITCNT_LAST);
	wire [2:0] op        = inst_reg[`DPS_OP_MSB:`DPS_OP_LSB];
	wire [4:0] addr      = inst_reg[`DPS_ADDR_MSB:`DPS_ADDR_LSB];
	wire [2:0] rx_op     = rx_next[`DPS_OP_MSB:`DPS_OP_LSB];
	wire [4:0] rx_addr   = rx_next[`DPS_ADDR_MSB:`DPS_ADDR_LSB];
	wire       vol       = acr_reg[`DPS_ACR_VOL];
	wire       open_drn  = acr_reg[`DPS_ACR_SDO_OD];
	wire       is_gp     = (ex_addr_reg >= `DPS_ADDR_GP_FIRST) &&
	                       (ex_addr_reg <= `DPS_ADDR_GP_LAST);

	wire       fifo_in_valid;
	wire       fifo_out_valid;
	wire       fifo_out_ready;
	wire [7:0] fifo_out_data;

	// data bytes of a write frame queue until chip select rises
	// a full queue refuses the push, so bytes past its depth are lost
	assign fifo_in_valid  = byte_done & inst_done_reg &
	                        (op == `DPS_OP_WRITE);
	assign fifo_out_ready = (ex_state_reg != EX_IDLE);

	dps_fifo #(
		.WIDTH (`DPS_FIFO_WIDTH),
		.DEPTH (`DPS_FIFO_DEPTH),
		.AW    (`DPS_FIFO_AW)
	) u_fifo (
		.clk       (core_clk),
		.reset     (reset),
		.clear     (1'b0),
		.in_valid  (fifo_in_valid),
		.in_ready  (),
		.in_data   (rx_next),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	dps_nv_timer #(
		.CYCLES (NV_WRITE_CYCLES)
	) u_nv_timer (
		.clk   (core_clk),
		.reset (reset),
		.start (nv_start_reg),
		.busy  (nv_busy)
	);

	// chip select syncs reset low so a select held over reset arms nothing
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sck_sync_reg <= 2'h0;
			cs_sync_reg  <= 2'h0;
			sdi_sync_reg <= 2'h0;
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], sck};
			cs_sync_reg  <= {cs_sync_reg[0], cs_n};
			sdi_sync_reg <= {sdi_sync_reg[0], sdi};
			sck_prev_reg <= sck_s;
			cs_prev_reg  <= cs_s;
		end
	end

	// serial receive and transmit
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			armed_reg       <= 1'b0;
			bit_cnt_reg     <= 3'h0;
			inst_done_reg   <= 1'b0;
			rx_reg          <= 8'h00;
			inst_reg        <= 8'h00;
			tx_reg          <= 8'h00;
			tx_bit_reg      <= 1'b0;
		end else begin
			if (cs_fall)
				armed_reg <= 1'b1;
			if (cs_rise) begin
				bit_cnt_reg     <= 3'h0;
				inst_done_reg   <= 1'b0;
				tx_bit_reg      <= 1'b0;
			end else if (selected && sck_rise) begin
				rx_reg      <= rx_next;
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
				if (bit_cnt_reg == `DPS_BITCNT_LAST) begin
					if (!inst_done_reg) begin
						inst_reg      <= rx_next;
						inst_done_reg <= 1'b1;
						if (rx_op == `DPS_OP_READ)
							tx_reg <= read_value(rx_addr);
					end else if (op == `DPS_OP_READ) begin
						tx_reg <= read_value(addr);
					end
				end
			end else if (selected && sck_fall && inst_done_reg &&
			             op == `DPS_OP_READ) begin
				tx_bit_reg <= tx_reg[7];
				tx_reg     <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	// output driver: flops only, released when not selected
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sdo_out <= 1'b0;
			sdo_oe  <= 1'b0;
		end else if (!selected) begin
			sdo_out <= 1'b0;
			sdo_oe  <= 1'b0;
		end else if (open_drn) begin
			sdo_out <= 1'b0;
			sdo_oe  <= ~tx_bit_reg;
		end else begin
			sdo_out <= tx_bit_reg;
			sdo_oe  <= 1'b1;
		end
	end

	// power state follows selection and the stored write
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			active_mode      <= 1'b0;
			nv_write_pending <= 1'b0;
		end else begin
			active_mode      <= selected | nv_busy;
			nv_write_pending <= nv_busy;
		end
	end

	// executor: replays queued data bytes after chip select rises
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ex_state_reg <= EX_IDLE;
			ex_addr_reg  <= 5'h00;
			ex_nv_reg    <= 1'b0;
			nv_start_reg <= 1'b0;
			acr_reg      <= `DPS_ACR_RESET;
			wiper0_code  <= `DPS_WIPER_RESET;
			wiper1_code  <= `DPS_WIPER_RESET;
			ivr0_reg     <= `DPS_IVR_RESET;
			ivr1_reg     <= `DPS_IVR_RESET;
			dcp_enable   <= ACR_RST[`DPS_ACR_SHDN];
		end else begin
			nv_start_reg <= 1'b0;
			dcp_enable   <= acr_reg[`DPS_ACR_SHDN];
			case (ex_state_reg)
			EX_IDLE: begin
				ex_nv_reg <= 1'b0;
				if (cs_rise && armed_reg && fifo_out_valid) begin
					ex_addr_reg <= addr;
					// writes are refused while a stored write runs
					if (inst_done_reg && op == `DPS_OP_WRITE &&
					    !nv_busy)
						ex_state_reg <= EX_DRAIN;
					else
						ex_state_reg <= EX_FLUSH;
				end
			end
			EX_DRAIN: begin
				if (fifo_out_valid) begin
					case (ex_addr_reg)
					`DPS_ADDR_WIPER0: begin
						wiper0_code <= fifo_out_data;
						if (!vol) begin
							ivr0_reg  <= fifo_out_data;
							ex_nv_reg <= 1'b1;
						end
					end
					`DPS_ADDR_WIPER1: begin
						wiper1_code <= fifo_out_data;
						if (!vol) begin
							ivr1_reg  <= fifo_out_data;
							ex_nv_reg <= 1'b1;
						end
					end
					`DPS_ADDR_ACR: begin
						acr_reg <= fifo_out_data & `DPS_ACR_WMASK;
					end
					default: begin
						if (is_gp && !vol)
							ex_nv_reg <= 1'b1;
					end
					endcase
				end else begin
					nv_start_reg <= ex_nv_reg;
					ex_state_reg <= EX_IDLE;
				end
			end
			EX_FLUSH: begin
				if (!fifo_out_valid)
					ex_state_reg <= EX_IDLE;
			end
			default: ex_state_reg <= EX_IDLE;
			endcase
		end
	end

	// general purpose storage holds no reset: it models stored memory
	always @(posedge core_clk) begin
		if (ex_state_reg == EX_DRAIN && fifo_out_valid && is_gp && !vol)
			gp_mem[ex_addr_reg[3:0]] <= fifo_out_data;
	end

	// value shifted out for a read of the given address
	function [7:0] read_value;
		input [4:0] a;
		begin
			if (a == `DPS_ADDR_ACR)
				read_value = acr_reg |
				             ({7'h00, nv_busy} << `DPS_ACR_WIP);
			else if (nv_busy)
				read_value = 8'h00;
			else if (a == `DPS_ADDR_WIPER0)
				read_value = vol ? wiper0_code : ivr0_reg;
			else if (a == `DPS_ADDR_WIPER1)
				read_value = vol ? wiper1_code : ivr1_reg;
			else if (a >= `DPS_ADDR_GP_FIRST && a <= `DPS_ADDR_GP_LAST &&
			         !vol)
				read_value = gp_mem[a[3:0]];
			else
				read_value = 8'h00;
		end
	endfunction
endmodule

// ### src/dps_map.vh
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// clock and timing
`define DPS_CORE_CLK_KHZ   25000
`define DPS_NV_WRITE_MS    20
`define DPS_NV_CNT_W       20

// serial framing
`define DPS_BYTE_BITS      8
`define DPS_BITCNT_LAST    3'h7

// instruction byte fields
`define DPS_OP_MSB         7
`define DPS_OP_LSB         5
`define DPS_ADDR_MSB       4
`define DPS_ADDR_LSB       0
`define DPS_OP_READ        3'h3
`define DPS_OP_WRITE       3'h6

// register addresses
`define DPS_ADDR_WIPER0    5'h00
`define DPS_ADDR_WIPER1    5'h01
`define DPS_ADDR_GP_FIRST  5'h02
`define DPS_ADDR_GP_LAST   5'h0E
`define DPS_ADDR_RSVD      5'h0F
`define DPS_ADDR_ACR       5'h10

// access control register bits
`define DPS_ACR_VOL        7
`define DPS_ACR_SHDN       6
`define DPS_ACR_WIP        5
`define DPS_ACR_SDO_OD     1
`define DPS_ACR_WMASK      8'hC2
`define DPS_ACR_RESET      8'h40

// wiper and stored values at reset
`define DPS_WIPER_RESET    8'h80
`define DPS_IVR_RESET      8'h80

// data path buffer
`define DPS_FIFO_WIDTH     8
`define DPS_FIFO_DEPTH     32
`define DPS_FIFO_AW        5

`endif

// ### src/dps_fifo.v
`timescale 1ns/1ps
module dps_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk,       // core clock
	input  wire             reset,     // async, active high
	input  wire             clear,     // drop all contents
	input  wire             in_valid,  // write request
	output wire             in_ready,  // room available
	input  wire [WIDTH-1:0] in_data,   // write data
	output wire             out_valid, // data available
	input  wire             out_ready, // read acknowledge
	output wire [WIDTH-1:0] out_data   // head of queue
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid & in_ready & ~clear;
	assign pop       = out_valid & out_ready & ~clear;

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else if (clear) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push & ~pop)
				count_reg <= count_reg + 1'b1;
			else if (pop & ~push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// ### src/dps_nv_timer.v
`timescale 1ns/1ps
`include "dps_map.vh"
module dps_nv_timer #(
	parameter CYCLES = 500000
) (
	input  wire clk,   // core clock
	input  wire reset, // async, active high
	input  wire start, // one-cycle start pulse
	output reg  busy   // write cycle running
);
	localparam integer              LAST_I = CYCLES - 1;
	localparam [`DPS_NV_CNT_W-1:0] LAST   = LAST_I[`DPS_NV_CNT_W-1:0];
	reg [`DPS_NV_CNT_W-1:0] cnt_reg;

	// start while busy is ignored: one cycle at a time
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			busy    <= 1'b0;
			cnt_reg <= {`DPS_NV_CNT_W{1'b0}};
		end else if (!busy) begin
			if (start) begin
				busy    <= 1'b1;
				cnt_reg <= {`DPS_NV_CNT_W{1'b0}};
			end
		end else if (cnt_reg == LAST) begin
			busy <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

// ### tb/dps_spi_port_asserts.sv
`timescale 1ns/1ps
module dps_spi_port_asserts #(
	parameter NV_WRITE_CYCLES = 500000
) (
	input wire       core_clk,        // core clock
	input wire       reset,           // async reset
	input wire       sck,             // serial clock
	input wire       cs_n,            // chip select
	input wire       sdi,             // serial in
	input wire       sdo_out,         // serial out level
	input wire       sdo_oe,          // serial out enable
	input wire [7:0] wiper0_code,     // wiper 0
	input wire [7:0] wiper1_code,     // wiper 1
	input wire       dcp_enable,      // shutdown control
	input wire       active_mode,     // not standby
	input wire       nv_write_pending // stored write busy
);
	reg        sck_d;
	reg [3:0]  fall_age;
	reg [5:0]  idle_cnt;
	reg [31:0] pend_cnt;

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sck_d    <= 1'b0;
			fall_age <= 4'hF;
			idle_cnt <= 6'h00;
			pend_cnt <= 32'h0;
		end else begin
			sck_d    <= sck;
			if (sck_d && !sck)
				fall_age <= 4'h0;
			else if (fall_age != 4'hF)
				fall_age <= fall_age + 4'h1;
			if (!cs_n || nv_write_pending)
				idle_cnt <= 6'h00;
			else if (idle_cnt != 6'h3F)
				idle_cnt <= idle_cnt + 6'h01;
			pend_cnt <= nv_write_pending ? pend_cnt + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_OE_OFF: assert property (cs_n [*6] |-> !sdo_oe)
		else $error("serial out driven while deselected");
	AST_SEL_ACTIVE: assert property (
		$fell(cs_n) ##1 !cs_n [*6] |-> active_mode)
		else $error("selected but not active");
	AST_PEND_ACTIVE: assert property (
		nv_write_pending [*2] |-> active_mode)
		else $error("standby during stored write");
	// margin covers executor drain before the write starts
	AST_STANDBY: assert property (idle_cnt >= 6'h30 |-> !active_mode)
		else $error("no standby while deselected and idle");
	AST_WIPER_ON_RISE: assert property (
		$changed(wiper0_code) || $changed(wiper1_code) |-> cs_n)
		else $error("wiper changed while selected");
	AST_NV_LEN: assert property ($fell(nv_write_pending) |->
		pend_cnt >= NV_WRITE_CYCLES - 1 && pend_cnt <= NV_WRITE_CYCLES + 1)
		else $error("stored write length wrong");
	AST_PEND_HOLD: assert property (nv_write_pending [*2] |->
		$stable(wiper0_code) && $stable(wiper1_code))
		else $error("wiper written during stored write");
	AST_OE_SELECTED: assert property ($rose(sdo_oe) |-> !cs_n)
		else $error("serial out enabled while deselected");
	AST_SDO_ON_FALL: assert property (
		sdo_oe && $past(sdo_oe) && !cs_n && $changed(sdo_out)
		|-> fall_age <= 4'h7)
		else $error("serial out changed away from falling clock");
endmodule

bind dps_spi_port dps_spi_port_asserts #(
	.NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) dps_spi_port_asserts_inst (
	.core_clk(core_clk), .reset(reset), .sck(sck), .cs_n(cs_n),
	.sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
	.wiper0_code(wiper0_code), .wiper1_code(wiper1_code),
	.dcp_enable(dcp_enable), .active_mode(active_mode),
	.nv_write_pending(nv_write_pending)
);

// ### tb/dps_host_model.sv
`timescale 1ns/1ps
module dps_host_model (
	input  wire core_clk, // pacing clock
	input  wire sdo_wire, // resolved serial out line
	output reg  sck,      // serial clock, idles low
	output reg  cs_n,     // chip select
	output reg  sdi       // serial data to device
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	task half;
		begin
			repeat (4) @(negedge core_clk);
		end
	endtask

	task xfer(input [7:0] tx, output [7:0] rx);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				sdi = tx[i];
				half;
				sck = 1'b1;
				rx[i] = sdo_wire;
				half;
				sck = 1'b0;
			end
		end
	endtask

	task frame(input [7:0] instr, input integer n, input [7:0] data,
		output [7:0] rx);
		integer k;
		begin
			cs_n = 1'b0;
			half;
			xfer(instr, rx);
			for (k = 0; k < n; k = k + 1)
				xfer(data, rx);
			// long lag keeps the last bit clear of deselect
			half;
			half;
			cs_n = 1'b1;
			sdi = ~sdi;
			repeat (80) @(negedge core_clk);
		end
	endtask
endmodule

// ### tb/test_dps_spi_port.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count = cmp_count + 1; if ((a) !== (b)) begin \
	failures = failures + 1; \
	$display("wrong value at %0t got %h expected %h", $time, a, b); end end
module test_dps_spi_port;
	localparam NVC = 600;
	reg        core_clk;
	reg        reset;
	wire       sck, cs_n, sdi, sdo_out, sdo_oe;
	wire       dcp_enable, active_mode, pend;
	wire [7:0] wiper0_code, wiper1_code;
	wire       sdo_wire = sdo_oe ? sdo_out : 1'b1; // pull-up when released
	integer    failures, cmp_count, m_acr, m_w0, m_w1, i, r;
	reg [7:0]  rx, v;

	dps_spi_port #(.NV_WRITE_CYCLES(NVC)) dps_spi_port_inst (
		.core_clk(core_clk), .reset(reset), .sck(sck), .cs_n(cs_n),
		.sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.wiper0_code(wiper0_code), .wiper1_code(wiper1_code),
		.dcp_enable(dcp_enable), .active_mode(active_mode),
		.nv_write_pending(pend));
	dps_host_model dps_host_model_inst (.core_clk(core_clk),
		.sdo_wire(sdo_wire), .sck(sck), .cs_n(cs_n), .sdi(sdi));

	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	task wr(input [4:0] a, input [7:0] d, input integer n);
		begin
			dps_host_model_inst.frame({3'h6, a}, n, d, rx);
			if (a == 5'h10)
				m_acr = d & 8'hC2;
			else if (a == 5'h00)
				m_w0 = d;
			else if (a == 5'h01)
				m_w1 = d;
			`CHK(wiper0_code, m_w0[7:0])
			`CHK(wiper1_code, m_w1[7:0])
			`CHK(dcp_enable, m_acr[6])
			`CHK(sdo_oe, 1'b0)
		end
	endtask

	task rd(input [4:0] a, input [7:0] e);
		begin
			dps_host_model_inst.frame({3'h3, a}, 1, 8'h00, rx);
			`CHK(rx, e)
		end
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// several times the expected run of about 9600 cycles
	initial begin
		#2000000;
		failures = failures + 1;
		end_of_test;
	end

	initial begin
		failures = 0;
		cmp_count = 0;
		m_acr = 8'h40;
		m_w0 = 8'h80;
		m_w1 = 8'h80;
		r = $urandom(32'h1695b983);
		reset = 1'b1;
		#1 dps_host_model_inst.cs_n = 1'b0;
		repeat (4) @(negedge core_clk);
		reset = 1'b0;
		`CHK(sdo_oe, 1'b0)
		dps_host_model_inst.frame(8'hC0, 1, 8'h11, rx);
		`CHK(wiper0_code, 8'h80)
		rd(5'h10, m_acr[7:0]);
		wr(5'h10, 8'hC0, 1);
		for (i = 0; i < 4; i = i + 1) begin
			r = $urandom;
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[7:0];
			wr(5'h00, v, 1);
			wr(5'h01, ~v, 1);
			rd(5'h01, ~v);
		end
		wr(5'h00, 8'h5C, 40);
		wr(5'h10, 8'hBF, 1);
		rd(5'h10, m_acr[7:0]);
		rd(5'h00, m_w0[7:0]);
		wr(5'h10, 8'h40, 1);
		r = $urandom;
		wr(5'h00, r[7:0], 1);
		`CHK(pend, 1'b1)
		`CHK(active_mode, 1'b1)
		rd(5'h10, m_acr[7:0] | 8'h20);
		dps_host_model_inst.frame(8'hC1, 1, 8'h5A, rx);
		`CHK(wiper1_code, m_w1[7:0])
		repeat (NVC) @(negedge core_clk);
		`CHK(pend, 1'b0)
		`CHK(active_mode, 1'b0)
		rd(5'h00, r[7:0]);
		wr(5'h05, ~r[7:0], 1);
		repeat (NVC) @(negedge core_clk);
		rd(5'h05, ~r[7:0]);
		rd(5'h0F, 8'h00);
		end_of_test;
	end
endmodule
